/* pkg/ext_datapath_params.svh */
`ifndef EXT_DATAPATH_PARAMS_SVH
`define EXT_DATAPATH_PARAMS_SVH

// Flag bit positions in the flag_o vector
`define FLG_CARRY 0
`define FLG_AUX 1
`define FLG_ZERO 2
`define FLG_OVF 3
`define FLG_SC 4
`define FLG_CZ 5

// Reset values
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00
`define TBL_RST 8'h00

// Last program page index
`define LAST_PAGE 8'hFF

// Cycles of a taken skip (skip instruction plus dummy)
`define SKIP_CYCLES 2

`endif

/* pkg/ext_datapath_pkg.sv */
package ext_datapath_pkg;

  // Operation codes issued by the sequencer
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    SUB_TO_ACC_OP = 5'h01,
    SUB_TO_MEM_OP = 5'h02,
    NIBBLE_SWAP_OP = 5'h03,
    NIBBLE_SWAP_ACC_OP = 5'h04,
    SKIP_ZERO_OP = 5'h05,
    COPY_SKIP_ZERO_OP = 5'h06,
    SKIP_BIT_ZERO_OP = 5'h07,
    SKIP_NONZERO_OP = 5'h08,
    TABLE_READ_CUR_OP = 5'h09,
    TABLE_READ_LAST_OP = 5'h0A,
    INC_TABLE_READ_CUR_OP = 5'h0B,
    INC_TABLE_READ_LAST_OP = 5'h0C,
    XOR_TO_ACC_OP = 5'h0D,
    XOR_TO_MEM_OP = 5'h0E
  } op_e;

  // Execution state; each path leaves idle and returns with one bit changing
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TFETCH = 2'b01,
    ST_SKIP = 2'b10
  } state_e;

  typedef logic [7:0] byte_t;

endpackage

/* pkg/alu_if.sv */
`timescale 1ns/10ps
// Operands in, results out of the arithmetic unit
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] diff;
  logic [5:0] sub_flags;
  logic [7:0] xr;
  logic [7:0] swp;
  modport unit (input a, input b, output diff, output sub_flags, output xr, output swp);
  modport user (output a, output b, input diff, input sub_flags, input xr, input swp);
endinterface

/* hw/alu_unit.sv */
`timescale 1ns/10ps
`include "ext_datapath_params.svh"
module alu_unit
  import ext_datapath_pkg::*;
(
  alu_if.unit alu
);

  // -------------------------------------------------------------------
  // Subtract with flag generation
  // -------------------------------------------------------------------
  wire [8:0] full_diff;
  wire [4:0] low_diff;
  wire ovf;
  wire [5:0] f;

  // Ninth bit is the borrow: set when the true difference is negative
  assign full_diff = {1'b0, alu.a} - {1'b0, alu.b};
  assign low_diff = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]};
  assign ovf = (alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ full_diff[7]);
  assign alu.diff = full_diff[7:0];
  assign f[`FLG_CARRY] = ~full_diff[8];
  assign f[`FLG_AUX] = ~low_diff[4];
  assign f[`FLG_ZERO] = (full_diff[7:0] == 8'h00);
  assign f[`FLG_OVF] = ovf;
  // Signed compare: sign of the result corrected by overflow
  assign f[`FLG_SC] = ~(full_diff[7] ^ ovf);
  assign f[`FLG_CZ] = f[`FLG_SC] & ~(full_diff[7:0] == 8'h00);
  assign alu.sub_flags = f;

  // Logic results
  assign alu.xr = alu.a ^ alu.b;
  assign alu.swp = {alu.b[3:0], alu.b[7:4]};

endmodule

/* hw/ext_datapath.sv */
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "ext_datapath_params.svh"
// Contract
// - Subtract to accumulator: acc <= acc - mem, memory untouched.
// - Subtract to memory: mem <= acc - mem, accumulator untouched.
// - Carry is 0 on negative difference, 1 on zero or positive.
// - Subtracts update overflow, zero, aux carry, carry, signed compare, compare zero.
// - Nibble swap exchanges memory byte halves, no flag change.
// - Swap-to-accumulator puts swapped byte in accumulator, memory unchanged.
// - Byte skip test skips next instruction when byte is zero.
// - Taken skip inserts a dummy cycle; skip lasts two cycles.
// - Copy-and-test loads byte into accumulator, skips when it is zero.
// - Bit skip test skips next instruction when selected bit is zero.
// - Current-page table read writes word low byte to memory.
// - All table reads load word high byte into latch, no flags.
// - Last-page table read uses last page with pointer low byte.
// - Increment-first read bumps pointer low byte before fetching.
// - Increment-first current read addresses with pointer high and low bytes.
// - Increment-first last-page read bumps low byte, fetches last page.
// - XOR to accumulator stores result in accumulator, zero flag only.
// - XOR to memory stores result in memory, zero flag only.
// - Skip-if-nonzero skips when byte is nonzero, same two-cycle timing.
module ext_datapath
  import ext_datapath_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic start_i,
  input wire logic [4:0] op_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [15:0] prog_rdata_i,
  input wire logic [7:0] ptr_high_wdata_i,
  input wire logic ptr_high_we_i,
  input wire logic [7:0] ptr_low_wdata_i,
  input wire logic ptr_low_we_i,
  output logic [7:0] acc_o,
  output logic [5:0] flag_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic [15:0] prog_addr_o,
  output logic prog_re_o,
  output logic [7:0] table_ptr_low_o,
  output logic [7:0] table_ptr_high_o,
  output logic [7:0] table_high_latch_o,
  output logic skip_o,
  output logic busy_o,
  output logic done_o
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  byte_t acc_reg, acc_next;
  logic [5:0] flag_reg, flag_next;
  byte_t mem_wdata_reg, mem_wdata_next;
  logic mem_we_reg, mem_we_next;
  logic [15:0] prog_addr_reg, prog_addr_next;
  logic prog_re_reg, prog_re_next;
  byte_t table_ptr_low_reg, table_ptr_low_next;
  byte_t table_ptr_high_reg, table_ptr_high_next;
  byte_t table_high_latch_reg, table_high_latch_next;
  logic skip_reg, skip_next;
  logic done_reg, done_next;
  state_e state_reg, state_next;
  logic busy_reg;

  alu_if alu();

  alu_unit u_alu (
    .alu(alu.unit)
  );

  assign alu.a = acc_reg;
  assign alu.b = mem_rdata_i;

  // -------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------
  // Operation decode is reused by the issue logic and the assertions
  function automatic logic is_table(input logic [4:0] op);
    is_table = (op == TABLE_READ_CUR_OP) || (op == TABLE_READ_LAST_OP) ||
               (op == INC_TABLE_READ_CUR_OP) || (op == INC_TABLE_READ_LAST_OP);
  endfunction

  function automatic logic is_skip(input logic [4:0] op);
    is_skip = (op == SKIP_ZERO_OP) || (op == COPY_SKIP_ZERO_OP) ||
              (op == SKIP_BIT_ZERO_OP) || (op == SKIP_NONZERO_OP);
  endfunction

  wire issue;
  wire mem_zero;
  wire bit_zero;
  wire skip_taken;
  wire inc_first;
  wire last_page;
  wire [7:0] ptr_low_eff;
  wire [7:0] page_eff;
  wire [5:0] zero_only_flags;
  wire busy_next;

  // Start is ignored while a table fetch or skip dummy is still in flight
  assign issue = en_i & start_i & (state_reg == ST_IDLE);
  assign mem_zero = (mem_rdata_i == 8'h00);
  assign bit_zero = ~mem_rdata_i[bit_sel_i];
  assign skip_taken = ((op_i == SKIP_ZERO_OP) & mem_zero) |
                      ((op_i == COPY_SKIP_ZERO_OP) & mem_zero) |
                      ((op_i == SKIP_BIT_ZERO_OP) & bit_zero) |
                      ((op_i == SKIP_NONZERO_OP) & ~mem_zero);
  assign inc_first = (op_i == INC_TABLE_READ_CUR_OP) || (op_i == INC_TABLE_READ_LAST_OP);
  assign last_page = (op_i == TABLE_READ_LAST_OP) || (op_i == INC_TABLE_READ_LAST_OP);
  assign ptr_low_eff = inc_first ? 8'(table_ptr_low_reg + 8'h01) : table_ptr_low_reg;
  // Last page ignores the high pointer; current page uses it
  assign page_eff = last_page ? `LAST_PAGE : table_ptr_high_reg;
  // Zero flag replaced, others kept
  assign zero_only_flags = (flag_reg & ~(6'h01 << `FLG_ZERO)) | ({5'h00, (alu.xr == 8'h00)} << `FLG_ZERO);
  // Busy is registered from the next state so the pin comes from a flop
  assign busy_next = (state_next != ST_IDLE);

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    acc_next = acc_reg;
    flag_next = flag_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_we_next = 1'b0;
    prog_addr_next = prog_addr_reg;
    prog_re_next = 1'b0;
    table_ptr_low_next = table_ptr_low_reg;
    table_ptr_high_next = table_ptr_high_reg;
    table_high_latch_next = table_high_latch_reg;
    skip_next = 1'b0;
    done_next = 1'b0;
    state_next = state_reg;
    if (ptr_low_we_i) begin
      table_ptr_low_next = ptr_low_wdata_i;
    end
    if (ptr_high_we_i) begin
      table_ptr_high_next = ptr_high_wdata_i;
    end
    case (state_reg)
      ST_IDLE: begin
        if (issue) begin
          case (op_i)
            SUB_TO_ACC_OP: begin
              acc_next = alu.diff;
              flag_next = alu.sub_flags;
              done_next = 1'b1;
            end
            SUB_TO_MEM_OP: begin
              mem_wdata_next = alu.diff;
              mem_we_next = 1'b1;
              flag_next = alu.sub_flags;
              done_next = 1'b1;
            end
            NIBBLE_SWAP_OP: begin
              mem_wdata_next = alu.swp;
              mem_we_next = 1'b1;
              done_next = 1'b1;
            end
            NIBBLE_SWAP_ACC_OP: begin
              acc_next = alu.swp;
              done_next = 1'b1;
            end
            XOR_TO_ACC_OP: begin
              acc_next = alu.xr;
              flag_next = zero_only_flags;
              done_next = 1'b1;
            end
            XOR_TO_MEM_OP: begin
              mem_wdata_next = alu.xr;
              mem_we_next = 1'b1;
              flag_next = zero_only_flags;
              done_next = 1'b1;
            end
            default: begin
              if (is_skip(op_i)) begin
                if (op_i == COPY_SKIP_ZERO_OP) begin
                  acc_next = mem_rdata_i;
                end
                if (skip_taken) begin
                  state_next = ST_SKIP;
                end else begin
                  done_next = 1'b1;
                end
              end else if (is_table(op_i)) begin
                // Plain reads keep a pointer write of the same cycle
                if (inc_first) begin
                  table_ptr_low_next = ptr_low_eff;
                end
                prog_addr_next = {page_eff, ptr_low_eff};
                prog_re_next = 1'b1;
                state_next = ST_TFETCH;
              end else begin
                done_next = 1'b1;
              end
            end
          endcase
        end
      end
      ST_TFETCH: begin
        // Program word arrives one cycle after the address
        mem_wdata_next = prog_rdata_i[7:0];
        mem_we_next = 1'b1;
        table_high_latch_next = prog_rdata_i[15:8];
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_SKIP: begin
        // Dummy cycle while the following instruction is discarded
        skip_next = 1'b1;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_reg <= `ACC_RST;
      flag_reg <= `FLAGS_RST;
      mem_wdata_reg <= 8'h00;
      mem_we_reg <= 1'b0;
      prog_addr_reg <= 16'h0000;
      prog_re_reg <= 1'b0;
      table_ptr_low_reg <= `TBL_RST;
      table_ptr_high_reg <= `TBL_RST;
      table_high_latch_reg <= `TBL_RST;
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
    end else if (en_i) begin
      acc_reg <= acc_next;
      flag_reg <= flag_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_we_reg <= mem_we_next;
      prog_addr_reg <= prog_addr_next;
      prog_re_reg <= prog_re_next;
      table_ptr_low_reg <= table_ptr_low_next;
      table_ptr_high_reg <= table_ptr_high_next;
      table_high_latch_reg <= table_high_latch_next;
      skip_reg <= skip_next;
      done_reg <= done_next;
      state_reg <= state_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flip-flops
  assign acc_o = acc_reg;
  assign flag_o = flag_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign mem_we_o = mem_we_reg;
  assign prog_addr_o = prog_addr_reg;
  assign prog_re_o = prog_re_reg;
  assign table_ptr_low_o = table_ptr_low_reg;
  assign table_ptr_high_o = table_ptr_high_reg;
  assign table_high_latch_o = table_high_latch_reg;
  assign skip_o = skip_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Subtract results and flags
  a_sub_acc_value: assert property (issue && op_i == SUB_TO_ACC_OP |=>
    acc_reg == 8'($past(acc_reg) - $past(mem_rdata_i)) && !mem_we_reg)
    else $error("subtract to acc wrong");
  a_sub_mem_value: assert property (issue && op_i == SUB_TO_MEM_OP |=>
    mem_we_reg && mem_wdata_reg == 8'($past(acc_reg) - $past(mem_rdata_i)) && $stable(acc_reg))
    else $error("subtract to mem wrong");
  a_sub_carry: assert property (issue && (op_i == SUB_TO_ACC_OP || op_i == SUB_TO_MEM_OP) |=>
    flag_reg[`FLG_CARRY] == ($past(acc_reg) >= $past(mem_rdata_i))) else $error("carry wrong");
  a_sub_zero: assert property (issue && op_i == SUB_TO_ACC_OP |=>
    flag_reg[`FLG_ZERO] == (acc_reg == 8'h00)) else $error("zero flag wrong");
  a_sub_mem_flags: assert property (issue && op_i == SUB_TO_MEM_OP |=>
    flag_reg[`FLG_ZERO] == (mem_wdata_reg == 8'h00)) else $error("mem zero flag wrong");

  // Nibble swaps
  a_swap_mem: assert property (issue && op_i == NIBBLE_SWAP_OP |=>
    mem_we_reg && mem_wdata_reg == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])} && $stable(flag_reg))
    else $error("swap wrong");
  a_swap_acc: assert property (issue && op_i == NIBBLE_SWAP_ACC_OP |=>
    !mem_we_reg && acc_reg == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])}) else $error("swap acc wrong");

  // Skip decisions and the one-cycle dummy; a new issue may follow the dummy at once
  a_skip_zero: assert property (issue && op_i == SKIP_ZERO_OP && mem_zero |=>
    busy_o ##1 skip_reg && done_reg) else $error("zero skip missed");
  a_skip_untaken: assert property (issue && is_skip(op_i) && !skip_taken |=>
    done_reg && !skip_reg && !busy_o) else $error("untaken skip wrong");
  a_skip_timing: assert property (issue && skip_taken |=>
    !done_reg && busy_o ##1 skip_reg && done_reg && !busy_o) else $error("skip timing wrong");
  a_copy_skip: assert property (issue && op_i == COPY_SKIP_ZERO_OP |=>
    acc_reg == $past(mem_rdata_i)) else $error("copy skip wrong");
  a_bit_noskip: assert property (issue && op_i == SKIP_BIT_ZERO_OP && !bit_zero |=>
    done_reg && !busy_o) else $error("bit skip wrong");
  a_bit_skip: assert property (issue && op_i == SKIP_BIT_ZERO_OP && bit_zero |->
    ##2 skip_reg && done_reg) else $error("bit zero skip missed");
  a_nonzero_skip: assert property (issue && op_i == SKIP_NONZERO_OP && !mem_zero |->
    ##2 skip_reg) else $error("nonzero skip missed");
  a_nonzero_stay: assert property (issue && op_i == SKIP_NONZERO_OP && mem_zero |=>
    done_reg && !skip_reg) else $error("nonzero skip on zero");

  // Table reads
  a_table_cur: assert property (issue && op_i == TABLE_READ_CUR_OP |=>
    prog_re_reg && prog_addr_reg == {$past(table_ptr_high_reg), $past(table_ptr_low_reg)})
    else $error("current page addr wrong");
  a_table_write: assert property (state_reg == ST_TFETCH && en_i |=>
    mem_we_reg && done_reg && !busy_o) else $error("table write back missing");
  a_table_latch: assert property (state_reg == ST_TFETCH && en_i |=>
    table_high_latch_reg == $past(prog_rdata_i[15:8]) && mem_wdata_reg == $past(prog_rdata_i[7:0]) &&
    $stable(flag_reg)) else $error("table read wrong");
  a_table_last: assert property (issue && op_i == TABLE_READ_LAST_OP |=>
    prog_addr_reg == {`LAST_PAGE, $past(table_ptr_low_reg)}) else $error("last page addr wrong");
  a_inc_bump: assert property (issue && inc_first && !ptr_low_we_i |=>
    table_ptr_low_reg == 8'($past(table_ptr_low_reg) + 8'h01)) else $error("pointer bump wrong");
  a_inc_cur: assert property (issue && op_i == INC_TABLE_READ_CUR_OP && !ptr_low_we_i |=>
    prog_addr_reg == {$past(table_ptr_high_reg), 8'($past(table_ptr_low_reg) + 8'h01)})
    else $error("inc read addr wrong");
  a_inc_last: assert property (issue && op_i == INC_TABLE_READ_LAST_OP && !ptr_low_we_i |=>
    prog_addr_reg == {`LAST_PAGE, 8'($past(table_ptr_low_reg) + 8'h01)}) else $error("inc last addr wrong");

  // Logic ops touch the zero flag only
  a_xor_acc: assert property (issue && op_i == XOR_TO_ACC_OP |=>
    acc_reg == ($past(acc_reg) ^ $past(mem_rdata_i)) && flag_reg[`FLG_CARRY] == $past(flag_reg[`FLG_CARRY]))
    else $error("xor wrong");
  a_xor_mem: assert property (issue && op_i == XOR_TO_MEM_OP |=>
    mem_we_reg && mem_wdata_reg == ($past(acc_reg) ^ $past(mem_rdata_i)) && $stable(acc_reg) &&
    flag_reg[`FLG_ZERO] == (mem_wdata_reg == 8'h00) && flag_reg[5:3] == $past(flag_reg[5:3]))
    else $error("xor to mem wrong");

  // Main scenarios
  c_skip_taken: cover property (issue && skip_taken ##2 skip_reg);
  c_table_read: cover property (issue && is_table(op_i) ##2 mem_we_reg);
  c_sub_borrow: cover property (issue && op_i == SUB_TO_ACC_OP && !alu.sub_flags[`FLG_CARRY]);
  c_last_page: cover property (issue && op_i == INC_TABLE_READ_LAST_OP ##2 done_reg);
  c_copy_skip: cover property (issue && op_i == COPY_SKIP_ZERO_OP && mem_zero ##2 skip_reg);

endmodule

/* tb/mem_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Data byte and program memory stand-in
// ----------------------------------------
module mem_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  input wire logic mem_we_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic prog_re_i,
  input wire logic [15:0] prog_addr_i,
  output logic [7:0] mem_rdata_o,
  output logic [15:0] prog_rdata_o
);
  logic [7:0] byte_reg = 8'h00;
  logic [15:0] idle_reg = 16'h0000;
  // Device write-back wins over a bench load in the same cycle
  always @(posedge clk_i) begin
    if (mem_we_i) byte_reg <= mem_wdata_i;
    else if (load_i) byte_reg <= load_data_i;
    idle_reg <= ~prog_rdata_o;
  end
  assign mem_rdata_o = byte_reg;
  // Word only valid while the read strobe stands; otherwise it toggles so stale data never matches
  assign prog_rdata_o = prog_re_i ? {~prog_addr_i[7:0], prog_addr_i[15:8] ^ prog_addr_i[7:0]} : idle_reg;
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench
  import ext_datapath_pkg::*;
;
  logic clk_i, nrst_i, en_i, start_i, ptr_high_we_i, ptr_low_we_i, load, mem_we_o, prog_re_o, skip_o, busy_o, done_o;
  logic [4:0] op_i;
  logic [2:0] bit_sel_i;
  logic [7:0] mem_rdata_i, ptr_high_wdata_i, ptr_low_wdata_i, load_data, acc_o, mem_wdata_o;
  logic [7:0] table_ptr_low_o, table_ptr_high_o, table_high_latch_o, wd;
  logic [15:0] prog_rdata_i, prog_addr_o, pa;
  logic [5:0] flag_o, f0;
  logic we, sk, re, bz;
  int miscompares = 0, n_tests = 0, n;
  byte_t av[4] = '{8'h30, 8'h80, 8'h47, 8'h10};
  byte_t bv[4] = '{8'h50, 8'h01, 8'h47, 8'h0F};
  op_e tops[4] = '{TABLE_READ_CUR_OP, TABLE_READ_LAST_OP, INC_TABLE_READ_CUR_OP, INC_TABLE_READ_LAST_OP};
  logic [15:0] ea[4] = '{16'h1234, 16'hFF34, 16'h1235, 16'hFF36};
  logic [7:0] pat = 8'hA5;
  logic [15:0] w;
  // ----------------------------------------
  // Design and memory stand-in
  // ----------------------------------------
  ext_datapath u_ext_datapath (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .start_i(start_i), .op_i(op_i),
    .bit_sel_i(bit_sel_i), .mem_rdata_i(mem_rdata_i), .prog_rdata_i(prog_rdata_i),
    .ptr_high_wdata_i(ptr_high_wdata_i), .ptr_high_we_i(ptr_high_we_i), .ptr_low_wdata_i(ptr_low_wdata_i),
    .ptr_low_we_i(ptr_low_we_i), .acc_o(acc_o), .flag_o(flag_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .prog_addr_o(prog_addr_o), .prog_re_o(prog_re_o), .table_ptr_low_o(table_ptr_low_o),
    .table_ptr_high_o(table_ptr_high_o), .table_high_latch_o(table_high_latch_o), .skip_o(skip_o),
    .busy_o(busy_o), .done_o(done_o));
  mem_model u_mem_model (.clk_i(clk_i), .load_i(load), .load_data_i(load_data), .mem_we_i(mem_we_o),
    .mem_wdata_i(mem_wdata_o), .prog_re_i(prog_re_o), .prog_addr_i(prog_addr_o), .mem_rdata_o(mem_rdata_i),
    .prog_rdata_o(prog_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Loads the data byte, issues one instruction and records what came back at done
  task automatic run(input op_e op, input logic [2:0] bs, input byte_t m);
    @(posedge clk_i);
    load <= 1'b1;
    load_data <= m;
    @(posedge clk_i);
    load <= 1'b0;
    op_i <= op;
    bit_sel_i <= bs;
    start_i <= 1'b1;
    n = 0;
    re = 1'b0;
    bz = 1'b0;
    do begin
      @(posedge clk_i);
      start_i <= 1'b0;
      #1;
      n++;
      if (n == 1) bz = busy_o;
      if (prog_re_o === 1'b1) begin
        re = 1'b1;
        pa = prog_addr_o;
      end
    end while (done_o !== 1'b1 && n < 8);
    if (done_o !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    we = mem_we_o;
    wd = mem_wdata_o;
    sk = skip_o;
  endtask
  task automatic setp(input byte_t h, input byte_t l);
    @(posedge clk_i);
    ptr_high_we_i <= 1'b1;
    ptr_high_wdata_i <= h;
    ptr_low_we_i <= 1'b1;
    ptr_low_wdata_i <= l;
    @(posedge clk_i);
    ptr_high_we_i <= 1'b0;
    ptr_low_we_i <= 1'b0;
  endtask
  // Flags {cz, sc, ov, z, aux, c}; aux means no borrow out of bit 3
  function automatic logic [5:0] fl(input byte_t a, input byte_t b);
    byte_t d;
    logic ov;
    d = a - b;
    ov = (a[7] != b[7]) && (d[7] != a[7]);
    return {~(d[7] ^ ov) & (d != 0), ~(d[7] ^ ov), ov, d == 0, a[3:0] >= b[3:0], a >= b};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst_i, start_i, ptr_high_we_i, ptr_low_we_i, load} = '0;
    en_i = 1'b1;
    {op_i, bit_sel_i, ptr_high_wdata_i, ptr_low_wdata_i, load_data} = '0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk({acc_o, 2'b00, flag_o}, 16'h0000);
    run(COPY_SKIP_ZERO_OP, 3'h0, 8'h5A);
    chk({acc_o, 7'h00, sk}, 16'h5A00);
    run(COPY_SKIP_ZERO_OP, 3'h0, 8'h00);
    chk({acc_o, 7'h00, sk}, 16'h0001);
    chk(n[15:0], 16'h0002);
    // Borrow, signed overflow, equal and half-borrow cases in both destinations
    for (int i = 0; i < 4; i++) begin
      run(COPY_SKIP_ZERO_OP, 3'h0, av[i]);
      run(SUB_TO_ACC_OP, 3'h0, bv[i]);
      chk({acc_o, 7'h00, we}, {av[i] - bv[i], 8'h00});
      chk(flag_o, fl(av[i], bv[i]));
      run(COPY_SKIP_ZERO_OP, 3'h0, av[i]);
      run(SUB_TO_MEM_OP, 3'h0, bv[i]);
      chk({wd, acc_o}, {av[i] - bv[i], av[i]});
      chk({we, 1'b0, n[5:0], 2'b00, flag_o}, {8'h81, 2'b00, fl(av[i], bv[i])});
    end
    f0 = flag_o;
    run(NIBBLE_SWAP_OP, 3'h0, 8'h3C);
    chk({wd, 7'h00, we}, 16'hC301);
    chk(flag_o, f0);
    run(NIBBLE_SWAP_ACC_OP, 3'h0, 8'h3C);
    chk({acc_o, 7'h00, we}, 16'hC300);
    chk(flag_o, f0);
    run(SKIP_ZERO_OP, 3'h0, 8'h00);
    chk({sk, bz, n[5:0]}, 8'hC2);
    run(SKIP_ZERO_OP, 3'h0, 8'h01);
    chk({sk, bz, n[5:0]}, 8'h01);
    run(SKIP_NONZERO_OP, 3'h0, 8'h80);
    chk({sk, bz, n[5:0]}, 8'hC2);
    run(SKIP_NONZERO_OP, 3'h0, 8'h00);
    chk({sk, bz, n[5:0]}, 8'h01);
    for (int b = 0; b < 8; b++) begin
      run(SKIP_BIT_ZERO_OP, b[2:0], pat);
      chk({sk, bz, n[5:0]}, pat[b] ? 8'h01 : 8'hC2);
    end
    // Each table read form, pointer bumps accumulating across the inc forms
    setp(8'h12, 8'h34);
    for (int i = 0; i < 4; i++) begin
      run(tops[i], 3'h0, 8'h00);
      w = {~ea[i][7:0], ea[i][15:8] ^ ea[i][7:0]};
      chk(pa, ea[i]);
      chk({table_ptr_low_o, 5'h00, bz, re, we}, {ea[i][7:0], 8'h07});
      chk({table_high_latch_o, wd}, w);
      chk({2'b00, flag_o, table_ptr_high_o}, {2'b00, f0, 8'h12});
    end
    // Low pointer wraps within eight bits
    setp(8'h12, 8'hFF);
    run(INC_TABLE_READ_CUR_OP, 3'h0, 8'h00);
    chk(pa, 16'h1200);
    chk({8'h00, table_ptr_low_o}, 16'h0000);
    run(COPY_SKIP_ZERO_OP, 3'h0, 8'h5A);
    run(XOR_TO_ACC_OP, 3'h0, 8'h5A);
    chk({acc_o, 2'b00, flag_o}, {8'h00, 2'b00, f0[5:3], 1'b1, f0[1:0]});
    run(COPY_SKIP_ZERO_OP, 3'h0, 8'h0F);
    run(XOR_TO_MEM_OP, 3'h0, 8'hF0);
    chk({wd, acc_o}, 16'hFF0F);
    chk({we, 1'b0, flag_o}, {2'b10, f0[5:3], 1'b0, f0[1:0]});
    // Clock enable low must freeze issue and pointer writes alike
    @(posedge clk_i);
    en_i <= 1'b0;
    op_i <= SUB_TO_ACC_OP;
    start_i <= 1'b1;
    ptr_low_we_i <= 1'b1;
    ptr_low_wdata_i <= 8'h99;
    repeat (3) @(posedge clk_i);
    #1;
    chk({acc_o, table_ptr_low_o}, 16'h0F00);
    chk({14'h0000, done_o, mem_we_o}, 16'h0000);
    @(posedge clk_i);
    en_i <= 1'b1;
    start_i <= 1'b0;
    ptr_low_we_i <= 1'b0;
    give_verdict();
  end
endmodule
